// >>> shared/fpu_ctx_defs.svh
// Register offsets, field positions, reset values and frame sizes
`ifndef FPU_CTX_DEFS_SVH
`define FPU_CTX_DEFS_SVH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define OFF_ENABLE      12'h000
`define OFF_STACK       12'h004
`define OFF_XEN         12'h008
`define OFF_MODE        12'h00C
`define OFF_STATUS      12'h010
`define OFF_INT_MASK    12'h014
`define OFF_CTX         12'h018

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define MODE_FLUSH_BIT  0
`define MODE_HALF_BIT   1
`define MODE_NAN_BIT    2
`define MODE_RND_LSB    3
`define STAT_FAULT_BIT  6
`define STAT_WIDTH      7

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define RST_ENABLE      1'h0
`define RST_STACK       2'h2
`define RST_XEN         6'h00
`define RST_MODE        5'h00
`define RST_MASK        7'h00

// ---------------------------------------------------------------------------
// Frame sizes in words
// ---------------------------------------------------------------------------
`define FRAME_INT_WORDS 5'h08
`define FRAME_FP_WORDS  5'h1A

`endif

// >>> shared/fpu_ctx_pkg.sv
// Types shared by the floating-point context controller
package fpu_ctx_pkg;

    typedef enum logic [1:0] {
        STACK_NONE   = 2'b00,
        STACK_ALWAYS = 2'b01,
        STACK_LAZY   = 2'b10
    } stack_policy_type;

    typedef enum logic [1:0] {
        RND_NEAREST = 2'b00,
        ROUND_UP    = 2'b01,
        ROUND_DOWN  = 2'b10,
        RND_ZERO    = 2'b11
    } round_mode_type;

    typedef enum logic [1:0] {
        CTX_IDLE    = 2'b00,
        CTX_HANDLER = 2'b01,
        CTX_SAVED   = 2'b10
    } ctx_state_type;

    // Arithmetic settings handed to the datapath
    typedef struct packed {
        logic           denorm_flush_on;
        logic           half_fmt_wide_range;
        logic           nan_force_canonical;
        round_mode_type round_mode;
    } arith_mode_type;

    // Six exception conditions reported by the datapath
    typedef struct packed {
        logic inexact;
        logic input_denormal;
        logic invalid_op;
        logic div_by_zero;
        logic overflow;
        logic underflow;
    } fp_exc_type;

    // Stacking directives to the core's exception sequencer
    typedef struct packed {
        logic [4:0] frame_words;
        logic       save_low_float_regs;
        logic       restore_low_float_regs;
    } stack_ctl_type;

    typedef struct packed {
        logic             enable;
        stack_policy_type policy;
        logic [5:0]       exc_enable;
        arith_mode_type   mode;
        logic [6:0]       status;
        logic [6:0]       mask;
        ctx_state_type    ctx;
        logic             frame_fp;
        logic [31:0]      prdata;
        stack_ctl_type    stack;
        logic             lazy_save;
        logic             irq;
    } state_type;

endpackage

// >>> verilog/fpu_context_control.sv
// Floating-point unit enable gate, context stacking policy and mode control
`timescale 1ns/1ns
`include "fpu_ctx_defs.svh"
// Functional notes
// RULE1: Unit resets disabled; software must enable before instructions run.
// RULE2: Issue while disabled is blocked and raises coprocessor fault.
// RULE3: Three entry policies selectable: none, always save, lazy save.
// RULE4: Policy none stacks only the integer volatile registers.
// RULE5: Always policy saves low float regs on entry, restores on return.
// RULE6: Float stacking grows the entry frame from 8 to 26 words.
// RULE7: Lazy is default; entry reserves float space, stacks integer only.
// RULE8: Lazy: first float instruction in handler saves context first.
// RULE9: Lazy: return restores float context only if it was saved.
// RULE10: Policy none leaves float registers unpreserved across interrupts.
// RULE11: Six exception conditions detected, each able to raise an interrupt.
// RULE12: Each exception interrupt is individually enabled by software.
// RULE13: Flush-to-zero defaults off; when on, near-zero values become zero.
// RULE14: Half-precision format defaults to IEEE; alternative has wider range.
// RULE15: NaN handling defaults to pass-through; else default NaN forced.
// RULE16: Rounding selects nearest, up, down or zero; defaults to nearest.
// RULE17: Software sets modes before float instructions, else defaults.
// RULE18: All control settings are software-writable and reset to defaults.
module fpu_context_control (
    input  wire logic                       core_clk,
    input  wire logic                       rstn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       fp_instr_valid,
    output logic                            fp_instr_ready,
    output logic                            fp_instr_exec,
    output logic                            coprocessor_absent_fault,
    input  wire logic                       irq_entry,
    input  wire logic                       irq_return,
    input  wire fpu_ctx_pkg::fp_exc_type    fp_exc,
    output fpu_ctx_pkg::arith_mode_type     arith_mode,
    output fpu_ctx_pkg::stack_ctl_type      stack_ctl,
    output logic                            lazy_save_req,
    output logic                            fpu_enabled,
    output logic                            irq
);

    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------
    fpu_ctx_pkg::state_type s_reg;
    fpu_ctx_pkg::state_type s_next;

    logic       wr_en;
    logic       rd_en;
    logic       hit;
    logic [6:0] events;
    logic       blocked;
    logic       lazy_hit;

    function automatic logic [6:0] w1c(input logic [6:0] cur,
                                       input logic [6:0] set,
                                       input logic [6:0] clr);
        // Set wins over a clear in the same cycle
        w1c = (cur & ~clr) | set;
    endfunction

    function automatic logic decode(input logic [11:0] a);
        decode = (a == `OFF_ENABLE) || (a == `OFF_STACK) ||
                 (a == `OFF_XEN) || (a == `OFF_MODE) ||
                 (a == `OFF_STATUS) || (a == `OFF_INT_MASK) ||
                 (a == `OFF_CTX);
    endfunction

    // -----------------------------------------------------------------------
    // APB access
    // -----------------------------------------------------------------------
    assign hit     = decode(paddr);
    assign wr_en   = psel && penable && pwrite && hit;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    // RULE2: disabled gate
    assign blocked  = fp_instr_valid && !s_reg.enable;
    // RULE8: lazy save first
    assign lazy_hit = fp_instr_valid && s_reg.enable &&
                      s_reg.ctx == fpu_ctx_pkg::CTX_HANDLER &&
                      s_reg.frame_fp;

    // RULE11: six conditions
    // RULE12: per-exception gating
    assign events = {blocked, fp_exc & s_reg.exc_enable};

    always_comb begin
        s_next = s_reg;
        s_next.lazy_save = 1'b0;
        s_next.stack.save_low_float_regs = 1'b0;
        s_next.stack.restore_low_float_regs = 1'b0;
        // RULE18: software control
        if (wr_en) begin
            case (paddr)
                `OFF_ENABLE: begin
                    // RULE1: enable bit
                    s_next.enable = pwdata[0];
                end
                `OFF_STACK: begin
                    // RULE3: policy select
                    if (pwdata[1:0] != 2'b11) begin
                        s_next.policy =
                            fpu_ctx_pkg::stack_policy_type'(pwdata[1:0]);
                    end
                end
                `OFF_XEN: begin
                    s_next.exc_enable = pwdata[5:0];
                end
                `OFF_MODE: begin
                    // RULE13: flush select
                    s_next.mode.denorm_flush_on =
                        pwdata[`MODE_FLUSH_BIT];
                    // RULE14: half format
                    s_next.mode.half_fmt_wide_range =
                        pwdata[`MODE_HALF_BIT];
                    // RULE15: NaN handling
                    s_next.mode.nan_force_canonical =
                        pwdata[`MODE_NAN_BIT];
                    // RULE16: rounding select
                    s_next.mode.round_mode = fpu_ctx_pkg::round_mode_type'(
                        pwdata[`MODE_RND_LSB+1:`MODE_RND_LSB]);
                end
                `OFF_INT_MASK: begin
                    s_next.mask = pwdata[6:0];
                end
                default: begin
                end
            endcase
        end
        s_next.status = w1c(s_reg.status, events,
                            (wr_en && paddr == `OFF_STATUS) ?
                            pwdata[6:0] : 7'h00);

        // Context tracking; nested entries are not tracked separately
        case (s_reg.ctx)
            fpu_ctx_pkg::CTX_IDLE: begin
                if (irq_entry) begin
                    s_next.ctx = fpu_ctx_pkg::CTX_HANDLER;
                    // RULE4: integer-only frame
                    // RULE10: no preservation
                    s_next.frame_fp = 1'b0;
                    s_next.stack.frame_words = `FRAME_INT_WORDS;
                    if (s_reg.policy == fpu_ctx_pkg::STACK_ALWAYS) begin
                        // RULE5: save on entry
                        // RULE6: larger frame
                        s_next.ctx = fpu_ctx_pkg::CTX_SAVED;
                        s_next.frame_fp = 1'b1;
                        s_next.stack.frame_words = `FRAME_FP_WORDS;
                        s_next.stack.save_low_float_regs = 1'b1;
                    end else if (s_reg.policy ==
                                 fpu_ctx_pkg::STACK_LAZY) begin
                        // RULE7: reserve only
                        s_next.frame_fp = 1'b1;
                        s_next.stack.frame_words = `FRAME_FP_WORDS;
                    end
                end
            end
            fpu_ctx_pkg::CTX_HANDLER: begin
                if (lazy_hit) begin
                    s_next.lazy_save = 1'b1;
                    s_next.stack.save_low_float_regs = 1'b1;
                    s_next.ctx = fpu_ctx_pkg::CTX_SAVED;
                end else if (irq_return) begin
                    // RULE9: nothing to restore
                    s_next.ctx = fpu_ctx_pkg::CTX_IDLE;
                end
            end
            fpu_ctx_pkg::CTX_SAVED: begin
                if (irq_return) begin
                    // RULE5: restore on return
                    // RULE9: restore when saved
                    s_next.stack.restore_low_float_regs = 1'b1;
                    s_next.ctx = fpu_ctx_pkg::CTX_IDLE;
                end
            end
            default: begin
                s_next.ctx = fpu_ctx_pkg::CTX_IDLE;
            end
        endcase

        s_next.irq = |(s_next.status & s_next.mask);
        s_next.prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                `OFF_ENABLE:   s_next.prdata = {31'h0, s_reg.enable};
                `OFF_STACK:    s_next.prdata = {30'h0, s_reg.policy};
                `OFF_XEN:      s_next.prdata = {26'h0, s_reg.exc_enable};
                `OFF_MODE:     s_next.prdata = {27'h0, s_reg.mode.round_mode,
                                   s_reg.mode.nan_force_canonical,
                                   s_reg.mode.half_fmt_wide_range,
                                   s_reg.mode.denorm_flush_on};
                `OFF_STATUS:   s_next.prdata = {25'h0, s_reg.status};
                `OFF_INT_MASK: s_next.prdata = {25'h0, s_reg.mask};
                `OFF_CTX:      s_next.prdata = {24'h0, s_reg.stack.frame_words,
                                   s_reg.frame_fp, s_reg.ctx};
                default:       s_next.prdata = 32'h0000_0000;
            endcase
        end else if (psel && penable) begin
            s_next.prdata = s_reg.prdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg.enable     <= `RST_ENABLE;
            s_reg.policy     <= fpu_ctx_pkg::stack_policy_type'(`RST_STACK);
            s_reg.exc_enable <= `RST_XEN;
            s_reg.mode       <= `RST_MODE;
            s_reg.status     <= 7'h00;
            s_reg.mask       <= `RST_MASK;
            s_reg.ctx        <= fpu_ctx_pkg::CTX_IDLE;
            s_reg.frame_fp   <= 1'b0;
            s_reg.prdata     <= 32'h0000_0000;
            s_reg.stack      <= {`FRAME_INT_WORDS, 2'b00};
            s_reg.lazy_save  <= 1'b0;
            s_reg.irq        <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // -----------------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------------
    assign prdata                   = s_reg.prdata;
    // Issue stalls two cycles so the save directive leads the instruction
    assign fp_instr_ready           = s_reg.enable && !lazy_hit &&
                                      !s_reg.lazy_save;
    assign fp_instr_exec            = fp_instr_valid && fp_instr_ready;
    assign coprocessor_absent_fault = blocked;
    assign arith_mode               = s_reg.mode;
    assign stack_ctl                = s_reg.stack;
    assign lazy_save_req            = s_reg.lazy_save;
    assign fpu_enabled              = s_reg.enable;
    assign irq                      = s_reg.irq;

    // -----------------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------------
    default clocking ast_clk @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    AST_DISABLED_NO_EXEC: assert property ( // RULE2
        !fpu_enabled |-> !fp_instr_exec)
        else $error("instruction executed while disabled");
    AST_FAULT_STICKY: assert property ( // RULE2
        coprocessor_absent_fault |=> s_reg.status[`STAT_FAULT_BIT])
        else $error("fault not recorded");
    AST_ALWAYS_FRAME: assert property ( // RULE6
        (irq_entry && s_reg.ctx == fpu_ctx_pkg::CTX_IDLE &&
         s_reg.policy == fpu_ctx_pkg::STACK_ALWAYS)
        |=> stack_ctl.save_low_float_regs && stack_ctl.frame_words == 5'h1A)
        else $error("always policy frame wrong");
    AST_NONE_FRAME: assert property ( // RULE4
        (irq_entry && s_reg.ctx == fpu_ctx_pkg::CTX_IDLE &&
         s_reg.policy == fpu_ctx_pkg::STACK_NONE)
        |=> stack_ctl.frame_words == 5'h08 && !stack_ctl.save_low_float_regs)
        else $error("none policy frame wrong");
    AST_LAZY_ENTRY: assert property ( // RULE7
        (irq_entry && s_reg.ctx == fpu_ctx_pkg::CTX_IDLE &&
         s_reg.policy == fpu_ctx_pkg::STACK_LAZY)
        |=> !stack_ctl.save_low_float_regs && stack_ctl.frame_words == 5'h1A)
        else $error("lazy entry wrote context");
    AST_LAZY_BEFORE: assert property ( // RULE8
        lazy_hit |-> !fp_instr_exec ##1 (lazy_save_req && !fp_instr_exec))
        else $error("lazy save not ahead of instruction");
    AST_LAZY_RESTORE: assert property ( // RULE9
        (irq_return && s_reg.ctx == fpu_ctx_pkg::CTX_HANDLER && !lazy_hit)
        |=> !stack_ctl.restore_low_float_regs)
        else $error("restore without save");
    AST_IRQ_LEVEL: assert property ( // RULE12
        irq == |(s_reg.status & s_reg.mask))
        else $error("interrupt level mismatch");
    COV_FAULT: cover property (@(posedge core_clk) coprocessor_absent_fault);
    COV_LAZY: cover property (@(posedge core_clk) lazy_save_req);
    COV_RESTORE: cover property (@(posedge core_clk)
        stack_ctl.restore_low_float_regs);

endmodule // fpu_context_control

// >>> testbench/fp_core_model.sv
// Behavioural processor core that issues float work, interrupts and exceptions
`timescale 1ns/1ns
module fp_core_model (
    input  wire logic               core_clk,
    input  wire logic               fp_instr_ready,
    output logic                    fp_instr_valid,
    output logic                    irq_entry,
    output logic                    irq_return,
    output fpu_ctx_pkg::fp_exc_type fp_exc
);
    initial begin
        fp_instr_valid = 1'b0;
        irq_entry      = 1'b0;
        irq_return     = 1'b0;
        fp_exc         = 6'h00;
    end

    // modes are programmed by the bench only after the first issues, which run with reset defaults
    // Held until taken; a short limit lets a refused issue fall away
    task automatic issue_instr(input int delay, input int max_wait);
        int n;
        n = 0;
        repeat (delay) @(posedge core_clk);
        @(posedge core_clk);
        fp_instr_valid <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (fp_instr_ready !== 1'b1 && n < max_wait);
        fp_instr_valid <= 1'b0;
    endtask

    task automatic pulse_irq(input logic ret);
        @(posedge core_clk);
        irq_entry  <= ~ret;
        irq_return <= ret;
        @(posedge core_clk);
        irq_entry  <= 1'b0;
        irq_return <= 1'b0;
    endtask

    task automatic raise_exc(input logic [5:0] bits);
        @(posedge core_clk);
        fp_exc <= bits;
        @(posedge core_clk);
        fp_exc <= 6'h00;
    endtask
endmodule // fp_core_model

// >>> testbench/fpu_context_control_tb_top.sv
// Self-checking bench for the floating-point context controller
`timescale 1ns/1ns
`include "fpu_ctx_defs.svh"
module fpu_context_control_tb_top;
    logic                        core_clk;
    logic                        rstn;
    logic                        psel;
    logic                        penable;
    logic                        pwrite;
    logic [11:0]                 paddr;
    logic [31:0]                 pwdata;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    logic                        fp_instr_valid;
    logic                        fp_instr_ready;
    logic                        fp_instr_exec;
    logic                        coprocessor_absent_fault;
    logic                        irq_entry;
    logic                        irq_return;
    fpu_ctx_pkg::fp_exc_type     fp_exc;
    fpu_ctx_pkg::arith_mode_type arith_mode;
    fpu_ctx_pkg::stack_ctl_type  stack_ctl;
    logic                        lazy_save_req;
    logic                        fpu_enabled;
    logic                        irq;
    int                          bad_count;
    int                          tests_run;
    int                          save_cnt, restore_cnt, lazy_cnt;
    int                          exec_cnt, fault_cnt;
    time                         save_t, exec_t;
    logic [31:0]                 rd;
    logic                        err;

    fpu_context_control u_fpu_context_control (
        .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fp_instr_valid(fp_instr_valid),
        .fp_instr_ready(fp_instr_ready), .fp_instr_exec(fp_instr_exec),
        .coprocessor_absent_fault(coprocessor_absent_fault),
        .irq_entry(irq_entry), .irq_return(irq_return), .fp_exc(fp_exc),
        .arith_mode(arith_mode), .stack_ctl(stack_ctl),
        .lazy_save_req(lazy_save_req), .fpu_enabled(fpu_enabled), .irq(irq));

    fp_core_model u_fp_core_model (
        .core_clk(core_clk), .fp_instr_ready(fp_instr_ready),
        .fp_instr_valid(fp_instr_valid), .irq_entry(irq_entry),
        .irq_return(irq_return), .fp_exc(fp_exc));

    always #4 core_clk = ~core_clk;

    // Pulses are one cycle wide, so the falling edge sees each once
    always @(negedge core_clk) begin
        if (stack_ctl.save_low_float_regs === 1'b1) begin
            save_cnt++;
            save_t = $time;
        end
        if (fp_instr_exec === 1'b1) begin
            exec_cnt++;
            exec_t = $time;
        end
        if (stack_ctl.restore_low_float_regs === 1'b1) restore_cnt++;
        if (lazy_save_req === 1'b1) lazy_cnt++;
        if (coprocessor_absent_fault === 1'b1) fault_cnt++;
    end

    task automatic check_word(input logic [31:0] got,
                              input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h exp %h",
                     $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_check(input logic [11:0] a, input logic [31:0] exp,
                            input string msg);
        apb(1'b0, a, 32'h00000000);
        check_word(rd, exp, msg);
    endtask

    task automatic settle();
        repeat (2) @(negedge core_clk);
    endtask

    task automatic test_reset();
        rd_check(`OFF_ENABLE, 32'h00000000, "enable reset");
        rd_check(`OFF_STACK, 32'h00000002, "policy reset");
        rd_check(`OFF_XEN, 32'h00000000, "exc enable reset");
        rd_check(`OFF_MODE, 32'h00000000, "mode reset");
        check_word({27'h0, arith_mode}, 32'h00000000, "mode pins");
        $display("test_reset done");
    endtask

    task automatic test_fault();
        int f0, e0;
        f0 = fault_cnt;
        e0 = exec_cnt;
        u_fp_core_model.issue_instr(0, 1);
        settle();
        check_word(32'(fault_cnt - f0), 32'h00000001, "fault");
        check_word(32'(exec_cnt - e0), 32'h00000000, "no exec");
        rd_check(`OFF_STATUS, 32'h00000040, "fault status");
        check_word({31'h0, irq}, 32'h00000000, "irq masked");
        apb(1'b1, `OFF_INT_MASK, 32'h00000040);
        settle();
        check_word({31'h0, irq}, 32'h00000001, "irq raised");
        apb(1'b1, `OFF_STATUS, 32'h00000040);
        settle();
        check_word({31'h0, irq}, 32'h00000000, "irq cleared");
        rd_check(`OFF_STATUS, 32'h00000000, "status cleared");
        apb(1'b1, `OFF_ENABLE, 32'h00000001);
        settle();
        check_word({31'h0, fpu_enabled}, 32'h00000001, "enabled");
        u_fp_core_model.issue_instr(3, 8);
        settle();
        check_word(32'(exec_cnt - e0), 32'h00000001, "exec");
        $display("test_fault done");
    endtask

    task automatic test_modes();
        logic [4:0] m;
        for (int r = 0; r < 4; r++) begin
            m = {2'(r), 3'h7 >> r};
            apb(1'b1, `OFF_MODE, {27'h0, m});
            settle();
            rd_check(`OFF_MODE, {27'h0, m}, "mode read");
            check_word({27'h0, arith_mode},
                       {27'h0, m[0], m[1], m[2], m[4:3]}, "mode pins");
        end
        $display("test_modes done");
    endtask

    task automatic test_policy(input int p, input logic use_fp);
        int s0, r0, l0;
        s0 = save_cnt;
        r0 = restore_cnt;
        l0 = lazy_cnt;
        apb(1'b1, `OFF_STACK, 32'(p));
        u_fp_core_model.pulse_irq(1'b0);
        settle();
        check_word({27'h0, stack_ctl.frame_words},
                   (p == 0) ? 32'h00000008 : 32'h0000001A, "frame");
        check_word(32'(save_cnt - s0), 32'(p == 1), "entry save");
        if (use_fp) begin
            u_fp_core_model.issue_instr(0, 10);
            settle();
            check_word(32'(lazy_cnt - l0), 32'(p == 2), "lazy req");
            check_word(32'(save_cnt - s0), 32'(p != 0), "save");
            check_word(32'(save_t < exec_t || p == 0),
                       32'h00000001, "save first");
        end
        u_fp_core_model.pulse_irq(1'b1);
        repeat (3) @(negedge core_clk);
        check_word(32'(restore_cnt - r0),
                   32'(p == 1 || (p == 2 && use_fp)), "restore");
        $display("test_policy %0d %0d done", p, use_fp);
    endtask

    task automatic test_exc();
        apb(1'b1, `OFF_STACK, 32'h00000003);
        rd_check(`OFF_STACK, 32'h00000002, "policy 3 refused");
        apb(1'b1, `OFF_XEN, 32'h0000002A);
        u_fp_core_model.raise_exc(6'h3F);
        settle();
        rd_check(`OFF_STATUS, 32'h0000002A, "status subset");
        apb(1'b1, `OFF_INT_MASK, 32'h00000008);
        settle();
        check_word({31'h0, irq}, 32'h00000001, "exc irq");
        apb(1'b1, `OFF_STATUS, 32'h00000008);
        settle();
        check_word({31'h0, irq}, 32'h00000000, "exc irq clear");
        rd_check(`OFF_STATUS, 32'h00000022, "w1c partial");
        apb(1'b1, `OFF_STATUS, 32'h00000022);
        apb(1'b1, `OFF_XEN, 32'h00000015);
        u_fp_core_model.raise_exc(6'h3F);
        settle();
        rd_check(`OFF_STATUS, 32'h00000015, "other subset");
        rd_check(12'h020, 32'h00000000, "unmapped data");
        check_word({31'h0, err}, 32'h00000001, "unmapped err");
        $display("test_exc done");
    endtask

    task automatic complete_run();
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        rstn     = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 12'h000;
        pwdata   = 32'h00000000;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        test_reset();
        test_fault();
        test_modes();
        test_policy(0, 1'b1);
        test_policy(1, 1'b1);
        test_policy(2, 1'b0);
        test_policy(2, 1'b1);
        test_exc();
        complete_run();
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule // fpu_context_control_tb_top
